// File: verilog/mad_decode.sv
// Purpose: program and data space address decode for a 16-bit core
// Assumes: CPU core drives requests synchronous to CLOCK_I
// Notes: data memory is held here; reads and writes use separate generators
// Overview of operation
// - program addresses are 24 bits, from the 23-bit counter or the table page and offset
// - user accesses stay in lower half; table ops with page bit 7 reach config
// - lower word at even address, upper word at odd; top byte unimplemented
// - program counter stays even and steps by two, up or down
// - reset fetches at zero; region below 000200h holds vectors
// - primary and alternate interrupt vector tables at fixed ranges
// - 256-word data EEPROM at top of user space, table ops only
// - eight configuration words decoded at fixed config addresses
// - separate read and write address generators run together
// - data addresses are 16-bit byte addresses; top bit selects window
// - 768 data words; reads of unimplemented locations return zero
// - low byte at even address, high byte at odd address
// - pointer post-modify steps one for bytes, two for words
// - byte read fetches whole word and puts chosen byte on low lane
// - shared word decode, separate byte strobes; byte write touches one lane
// - odd word access traps; misaligned write is suppressed
// - byte load into a working register keeps its high byte
// - sign-extend widens 8 to 16 bits; zero-extend clears high byte
// - near region reached by 13-bit direct field; beyond it indirectly or by a move's 16-bit direct address
// - moves use a full 16-bit direct address
// - program window visible only while visibility enable bit is set
`timescale 1ns/10ps
`include "mad_defs.svh"
module mad_decode #(
    parameter int DATA_WORDS = `MAD_DATA_WORDS,
    parameter int EE_WORDS = `MAD_EE_WORDS
) (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic PC_STEP_I,
    input wire logic PC_DOWN_I,
    input wire logic PC_LOAD_I,
    input wire logic [22:0] PC_LOAD_VAL_I,
    input wire logic TABLE_READ_OP_I,
    input wire logic TABLE_WRITE_OP_I,
    input wire logic [7:0] TABLE_PAGE_REG_I,
    input wire logic [15:0] TABLE_OFFSET_I,
    input wire logic [15:0] TABLE_WDATA_I,
    input wire logic PROGRAM_SPACE_WINDOW_I,
    input wire logic [15:0] SOURCE_POINTER_REG_I,
    input wire logic POST_INC_I,
    input wire logic DIRECT_NEAR_I,
    input wire logic [12:0] NEAR_FIELD_I,
    input wire logic MEMORY_DIRECT_ADDRESSING_I,
    input wire logic [15:0] DIRECT_FIELD_I,
    input wire logic RD_EN_I,
    input wire logic RD_BYTE_I,
    input wire logic [15:0] RD_OLD_I,
    input wire logic SIGN_EXTEND_OP_I,
    input wire logic ZERO_EXTEND_OP_I,
    input wire logic WR_EN_I,
    input wire logic WR_BYTE_I,
    input wire logic [15:0] WR_ADDR_I,
    input wire logic [15:0] WR_DATA_I,
    input wire logic TRAP_TAKEN_I,
    output logic [23:0] FETCH_ADDR_O,
    output logic [23:0] TABLE_ADDR_O,
    output logic [2:0] TABLE_REGION_O,
    output logic [3:0] CFG_WORD_O,
    output logic TABLE_DENIED_O,
    output logic [15:0] TABLE_RDATA_O,
    output logic IN_IVT_O,
    output logic IN_ALT_IVT_O,
    output logic [15:0] RD_ADDR_O,
    output logic RD_WINDOW_O,
    output logic [15:0] RD_DATA_O,
    output logic [15:0] POINTER_NEXT_O,
    output logic ADDR_TRAP_O
);
    logic [22:0] pc_reg;
    logic [15:0] mem_word;
    logic [15:0] ee_mem [EE_WORDS];
    logic [15:0] rd_data_reg;
    logic [15:0] table_rdata_reg;
    logic trap_reg;
    logic [15:0] rd_ea;
    logic rd_word_ok;
    logic wr_word_ok;
    logic rd_misaligned;
    logic wr_misaligned;
    logic [15:0] raw_word;
    logic [15:0] lane_out;
    logic [15:0] pc_delta;
    logic [23:0] table_addr;
    logic [23:0] odd_base;
    logic table_upper;
    mad_pkg::mad_region_t region;
    mad_pkg::mad_cfg_t cfg_word;
    logic [1:0] wr_lane;
    logic [7:0] ee_index;
    logic ee_hit;
    logic [15:0] rd_idx;
    logic [15:0] wr_idx;

    // program counter: load clears bit 0 and steps are by two, so it cannot go odd
    always_ff @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            pc_reg <= 23'h000000;
        end
        else if (PC_LOAD_I)
        begin
            pc_reg <= {PC_LOAD_VAL_I[22:1], 1'b0};
        end
        else if (PC_STEP_I)
        begin
            if (PC_DOWN_I)
            begin
                pc_reg <= pc_reg - 23'h000002;
            end
            else
            begin
                pc_reg <= pc_reg + 23'h000002;
            end
        end
    end
    assign FETCH_ADDR_O = {1'b0, pc_reg};
    assign IN_IVT_O = (FETCH_ADDR_O >= `MAD_IVT_LO) && (FETCH_ADDR_O <= `MAD_IVT_HI);
    assign IN_ALT_IVT_O = (FETCH_ADDR_O >= `MAD_AIVT_LO) && (FETCH_ADDR_O <= `MAD_AIVT_HI);

    // table address: page supplies the top byte, offset the low sixteen bits
    assign table_addr = {TABLE_PAGE_REG_I, TABLE_OFFSET_I};
    assign table_upper = table_addr[0];
    assign odd_base = {table_addr[23:1], 1'b0};
    assign ee_index = odd_base[8:1];
    assign TABLE_ADDR_O = table_addr;

    always_comb
    begin
        cfg_word = mad_pkg::MAD_CFG_NONE;
        if (odd_base == `MAD_CFG_BS) cfg_word = mad_pkg::MAD_CFG_BOOT_SEGMENT;
        else if (odd_base == `MAD_CFG_GS) cfg_word = mad_pkg::MAD_CFG_GENERAL_SEGMENT;
        else if (odd_base == `MAD_CFG_OSEL) cfg_word = mad_pkg::MAD_CFG_OSC_SELECT;
        else if (odd_base == `MAD_CFG_OSC) cfg_word = mad_pkg::MAD_CFG_OSCILLATOR;
        else if (odd_base == `MAD_CFG_WDT) cfg_word = mad_pkg::MAD_CFG_WATCHDOG;
        else if (odd_base == `MAD_CFG_POR) cfg_word = mad_pkg::MAD_CFG_POWER_ON_RESET;
        else if (odd_base == `MAD_CFG_DBG) cfg_word = mad_pkg::MAD_CFG_DEBUG;
        else if (odd_base == `MAD_CFG_DS) cfg_word = mad_pkg::MAD_CFG_DEEP_SLEEP;
    end

    always_comb
    begin
        if (table_addr[23])
        begin
            // upper half only for table ops with the page's top bit set
            if ((TABLE_READ_OP_I || TABLE_WRITE_OP_I) &&
                TABLE_PAGE_REG_I[`MAD_TABLE_PAGE_REG_CFG_BIT])
            begin
                region = mad_pkg::MAD_REG_CONFIG;
            end
            else
            begin
                region = mad_pkg::MAD_REG_DENIED;
            end
        end
        else if (table_addr >= `MAD_EE_LO)
        begin
            region = mad_pkg::MAD_REG_EEPROM;
        end
        else if (table_addr < `MAD_VEC_END)
        begin
            region = mad_pkg::MAD_REG_VECTOR;
        end
        else
        begin
            region = mad_pkg::MAD_REG_USER;
        end
    end
    assign TABLE_REGION_O = region;
    assign CFG_WORD_O = (region == mad_pkg::MAD_REG_CONFIG) ? cfg_word : mad_pkg::MAD_CFG_NONE;
    assign TABLE_DENIED_O = (region == mad_pkg::MAD_REG_DENIED);
    // eeprom answers only to table operations
    assign ee_hit = (region == mad_pkg::MAD_REG_EEPROM);

    always_ff @(posedge CLOCK_I)
    begin
        if (TABLE_WRITE_OP_I && ee_hit && !table_upper)
        begin
            ee_mem[ee_index] <= TABLE_WDATA_I;
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            table_rdata_reg <= 16'h0000;
        end
        else if (TABLE_READ_OP_I)
        begin
            // eeprom is 16 bits wide: its upper word reads zero
            if (ee_hit && !table_upper)
            begin
                table_rdata_reg <= ee_mem[ee_index];
            end
            else
            begin
                table_rdata_reg <= 16'h0000;
            end
        end
    end
    assign TABLE_RDATA_O = table_rdata_reg;

    // read generator picks its effective address by addressing mode
    always_comb
    begin
        if (MEMORY_DIRECT_ADDRESSING_I)
        begin
            rd_ea = DIRECT_FIELD_I;
        end
        else if (DIRECT_NEAR_I)
        begin
            rd_ea = {3'b000, NEAR_FIELD_I};
        end
        else
        begin
            rd_ea = SOURCE_POINTER_REG_I;
        end
    end
    assign RD_ADDR_O = rd_ea;
    assign POINTER_NEXT_O = SOURCE_POINTER_REG_I + pc_delta;
    assign pc_delta = POST_INC_I ? (RD_BYTE_I ? 16'h0001 : 16'h0002) : 16'h0000;
    assign RD_WINDOW_O = rd_ea[15] && PROGRAM_SPACE_WINDOW_I;

    assign rd_idx = {1'b0, rd_ea[15:1]};
    assign wr_idx = {1'b0, WR_ADDR_I[15:1]};
    assign rd_word_ok = !rd_ea[15] && (rd_idx < 16'(DATA_WORDS));
    assign wr_word_ok = !WR_ADDR_I[15] && (wr_idx < 16'(DATA_WORDS));
    assign rd_misaligned = RD_EN_I && !RD_BYTE_I && rd_ea[0];
    assign wr_misaligned = WR_EN_I && !WR_BYTE_I && WR_ADDR_I[0];
    assign raw_word = rd_word_ok ? mem_word : 16'h0000;

    mad_data_lane u_lane (
        .word_i(raw_word),
        .byte_sel_i(rd_ea[0]),
        .byte_op_i(RD_BYTE_I),
        .old_i(RD_OLD_I),
        .sign_extend_op_i(SIGN_EXTEND_OP_I),
        .zero_extend_op_i(ZERO_EXTEND_OP_I),
        .load_o(lane_out)
    );

    // misaligned read still completes with the aligned word
    always_ff @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            rd_data_reg <= 16'h0000;
        end
        else if (RD_EN_I)
        begin
            rd_data_reg <= lane_out;
        end
    end
    assign RD_DATA_O = rd_data_reg;

    // byte strobes: even address is the low lane
    always_comb
    begin
        wr_lane = 2'b00;
        if (WR_EN_I && wr_word_ok && !wr_misaligned)
        begin
            if (WR_BYTE_I)
            begin
                wr_lane = WR_ADDR_I[0] ? 2'b10 : 2'b01;
            end
            else
            begin
                wr_lane = 2'b11;
            end
        end
    end

    // independent write port runs alongside the read port
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_lane
            logic [7:0] lane_mem [DATA_WORDS];
            always_ff @(posedge CLOCK_I)
            begin
                if (wr_lane[g])
                begin
                    lane_mem[wr_idx[9:0]] <= WR_BYTE_I ? WR_DATA_I[7:0]
                                                       : WR_DATA_I[g*8 +: 8];
                end
            end
            assign mem_word[g*8 +: 8] = lane_mem[rd_idx[9:0]];
        end
    endgenerate

    // trap request: combinational on detection, then held until taken
    always_ff @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            trap_reg <= 1'b0;
        end
        else if (rd_misaligned || wr_misaligned)
        begin
            trap_reg <= 1'b1;
        end
        else if (TRAP_TAKEN_I)
        begin
            trap_reg <= 1'b0;
        end
    end
    assign ADDR_TRAP_O = trap_reg || rd_misaligned || wr_misaligned;
endmodule

// File: verilog/mad_defs.svh
// Purpose: constants for the memory address decode block
// Assumes: 24-bit program addresses, 16-bit byte-addressed data space
// Notes: all offsets and field positions live here as macros
`ifndef MAD_DEFS_SVH
`define MAD_DEFS_SVH
`define MAD_PADDR_W 24
`define MAD_PC_W 23
`define MAD_USER_TOP 24'h7FFFFF
`define MAD_RESET_VEC 24'h000000
`define MAD_RESET_TGT 24'h000002
`define MAD_VEC_END 24'h000200
`define MAD_IVT_LO 24'h000004
`define MAD_IVT_HI 24'h0000FF
`define MAD_AIVT_LO 24'h000104
`define MAD_AIVT_HI 24'h0001FF
`define MAD_EE_LO 24'h7FFE00
`define MAD_EE_HI 24'h7FFFFF
`define MAD_EE_WORDS 256
`define MAD_CFG_BS 24'hF80000
`define MAD_CFG_GS 24'hF80004
`define MAD_CFG_OSEL 24'hF80006
`define MAD_CFG_OSC 24'hF80008
`define MAD_CFG_WDT 24'hF8000A
`define MAD_CFG_POR 24'hF8000C
`define MAD_CFG_DBG 24'hF8000E
`define MAD_CFG_DS 24'hF80010
`define MAD_TABLE_PAGE_REG_CFG_BIT 7
`define MAD_DATA_WORDS 768
`define MAD_NEAR_TOP 16'h1FFF
`define MAD_NEAR_W 13
`endif

// File: verilog/mad_pkg.sv
// Purpose: types for the memory address decode block
// Assumes: included constants come from mad_defs.svh
// Notes: region and configuration word enumerations
package mad_pkg;
    typedef enum logic [2:0] {
        MAD_REG_VECTOR,
        MAD_REG_USER,
        MAD_REG_EEPROM,
        MAD_REG_CONFIG,
        MAD_REG_DENIED
    } mad_region_t;
    typedef enum logic [3:0] {
        MAD_CFG_NONE,
        MAD_CFG_BOOT_SEGMENT,
        MAD_CFG_GENERAL_SEGMENT,
        MAD_CFG_OSC_SELECT,
        MAD_CFG_OSCILLATOR,
        MAD_CFG_WATCHDOG,
        MAD_CFG_POWER_ON_RESET,
        MAD_CFG_DEBUG,
        MAD_CFG_DEEP_SLEEP
    } mad_cfg_t;
endpackage

// File: verilog/mad_data_lane.sv
// Purpose: byte lane steering and extension for one data word
// Assumes: even byte address is the low byte of a word
// Notes: purely combinational
`timescale 1ns/10ps
module mad_data_lane (
    input wire logic [15:0] word_i,
    input wire logic byte_sel_i,
    input wire logic byte_op_i,
    input wire logic [15:0] old_i,
    input wire logic sign_extend_op_i,
    input wire logic zero_extend_op_i,
    output logic [15:0] load_o
);
    logic [7:0] picked;
    always_comb
    begin
        picked = byte_sel_i ? word_i[15:8] : word_i[7:0];
        // extension works on the byte that the lane select delivered, not always the even one
        if (sign_extend_op_i)
        begin
            load_o = {{8{picked[7]}}, picked};
        end
        else if (zero_extend_op_i)
        begin
            load_o = {8'h00, picked};
        end
        else if (byte_op_i)
        begin
            load_o = {old_i[15:8], picked};
        end
        else
        begin
            load_o = word_i;
        end
    end
endmodule

// File: testbench/mad_decode_assertions.sv
// Purpose: port-level checker for the memory address decode block
// Assumes: one clock domain, synchronous active high reset
// Notes: bound to mad_decode after the module
`timescale 1ns/10ps
module mad_decode_assertions (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic PC_STEP_I,
    input wire logic PC_DOWN_I,
    input wire logic PC_LOAD_I,
    input wire logic PROGRAM_SPACE_WINDOW_I,
    input wire logic DIRECT_NEAR_I,
    input wire logic [12:0] NEAR_FIELD_I,
    input wire logic MEMORY_DIRECT_ADDRESSING_I,
    input wire logic [15:0] DIRECT_FIELD_I,
    input wire logic RD_EN_I,
    input wire logic RD_BYTE_I,
    input wire logic WR_EN_I,
    input wire logic WR_BYTE_I,
    input wire logic [15:0] WR_ADDR_I,
    input wire logic TRAP_TAKEN_I,
    input wire logic [23:0] FETCH_ADDR_O,
    input wire logic [15:0] RD_ADDR_O,
    input wire logic RD_WINDOW_O,
    input wire logic [15:0] RD_DATA_O,
    input wire logic ADDR_TRAP_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    logic mis;
    assign mis = (RD_EN_I && !RD_BYTE_I && RD_ADDR_O[0]) || (WR_EN_I && !WR_BYTE_I && WR_ADDR_I[0]);
    a_pc_step: assert property ((PC_STEP_I && !PC_LOAD_I) |=> FETCH_ADDR_O ==
        ($past(PC_DOWN_I) ? $past(FETCH_ADDR_O) - 24'h2 : $past(FETCH_ADDR_O) + 24'h2))
        else $error("pc step wrong");
    a_pc_reset: assert property ($fell(SYS_RST_I) |-> FETCH_ADDR_O == 24'h0)
        else $error("pc not zero after reset");
    a_trap_now: assert property (mis |-> ADDR_TRAP_O)
        else $error("misaligned access without trap");
    a_trap_hold: assert property (ADDR_TRAP_O && !TRAP_TAKEN_I |=> ADDR_TRAP_O)
        else $error("trap dropped early");
    a_trap_drop: assert property (!mis && TRAP_TAKEN_I ##1 !mis |-> !ADDR_TRAP_O)
        else $error("trap stays after taken");
    a_near_sel: assert property (DIRECT_NEAR_I && !MEMORY_DIRECT_ADDRESSING_I |->
        RD_ADDR_O == {3'h0, NEAR_FIELD_I})
        else $error("near field address wrong");
    a_direct_sel: assert property (MEMORY_DIRECT_ADDRESSING_I |-> RD_ADDR_O == DIRECT_FIELD_I)
        else $error("direct address wrong");
    a_window_gate: assert property (RD_WINDOW_O |-> RD_ADDR_O[15] && PROGRAM_SPACE_WINDOW_I)
        else $error("window selected wrongly");
    a_rd_zero: assert property (RD_EN_I && !RD_BYTE_I && RD_ADDR_O >= 16'h0600
        && !RD_ADDR_O[15] |=> RD_DATA_O == 16'h0)
        else $error("unimplemented read not zero");
endmodule
bind mad_decode mad_decode_assertions u_mad_decode_assertions (.*);

// File: testbench/mad_core_model.sv
// Purpose: core-side model that takes address error traps
// Assumes: one clock, synchronous reset
// Notes: a fixed delay stands in for the pipeline draining before the trap
`timescale 1ns/10ps
module mad_core_model #(
    parameter int ACK_DELAY = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic trap_i,
    output logic taken_o
);
    int cnt_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !trap_i || (cnt_reg == ACK_DELAY))
        begin
            cnt_reg <= 0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1;
        end
    end
    // one-cycle acknowledge once the request has waited ACK_DELAY edges
    always_ff @(posedge clk_i)
    begin
        taken_o <= !rst_i && trap_i && (cnt_reg == ACK_DELAY);
    end
endmodule

// File: testbench/tb.sv
// Purpose: self-checking bench for the memory address decode block
// Assumes: reads are issued through the direct address field, apart from one near-field read in t_agu
// Notes: data memory is not reset, so every word is written before read
`timescale 1ns/10ps
module tb;
    logic CLOCK_I = 1'b0, SYS_RST_I = 1'b1, PC_STEP_I = 1'b0, PC_DOWN_I = 1'b0;
    logic PC_LOAD_I = 1'b0, TABLE_READ_OP_I = 1'b0, TABLE_WRITE_OP_I = 1'b0;
    logic [22:0] PC_LOAD_VAL_I = 23'h0;
    logic [7:0] TABLE_PAGE_REG_I = 8'h0;
    logic [15:0] TABLE_OFFSET_I = 16'h0, TABLE_WDATA_I = 16'h0, SOURCE_POINTER_REG_I = 16'h0;
    logic PROGRAM_SPACE_WINDOW_I = 1'b0, POST_INC_I = 1'b0, DIRECT_NEAR_I = 1'b0;
    logic [12:0] NEAR_FIELD_I = 13'h0;
    logic MEMORY_DIRECT_ADDRESSING_I = 1'b0, RD_EN_I = 1'b0, RD_BYTE_I = 1'b0;
    logic [15:0] DIRECT_FIELD_I = 16'h0, RD_OLD_I = 16'h0, WR_ADDR_I = 16'h0, WR_DATA_I = 16'h0;
    logic SIGN_EXTEND_OP_I = 1'b0, ZERO_EXTEND_OP_I = 1'b0, WR_EN_I = 1'b0, WR_BYTE_I = 1'b0;
    logic TRAP_TAKEN_I, TABLE_DENIED_O, IN_IVT_O, IN_ALT_IVT_O, RD_WINDOW_O, ADDR_TRAP_O;
    logic [23:0] FETCH_ADDR_O, TABLE_ADDR_O;
    logic [2:0] TABLE_REGION_O;
    logic [3:0] CFG_WORD_O;
    logic [15:0] TABLE_RDATA_O, RD_ADDR_O, RD_DATA_O, POINTER_NEXT_O;
    int n_errors = 0;
    int tests_run = 0;
    mad_decode u_mad_decode (.*);
    mad_core_model u_mad_core_model (.clk_i(CLOCK_I), .rst_i(SYS_RST_I),
        .trap_i(ADDR_TRAP_O), .taken_o(TRAP_TAKEN_I));
    initial forever #5 CLOCK_I = ~CLOCK_I;
    task automatic chk(input logic [23:0] got, input logic [23:0] want);
        tests_run++;
        if (got !== want)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic bt, input logic [15:0] a, input logic [15:0] d);
        @(posedge CLOCK_I);
        WR_EN_I <= 1'b1;
        WR_BYTE_I <= bt;
        WR_ADDR_I <= a;
        WR_DATA_I <= d;
        @(posedge CLOCK_I);
        WR_EN_I <= 1'b0;
    endtask
    task automatic rd(input logic bt, input logic [15:0] a, input logic [15:0] old,
        input logic [15:0] want);
        @(posedge CLOCK_I);
        RD_EN_I <= 1'b1;
        RD_BYTE_I <= bt;
        MEMORY_DIRECT_ADDRESSING_I <= 1'b1;
        DIRECT_FIELD_I <= a;
        RD_OLD_I <= old;
        @(posedge CLOCK_I);
        RD_EN_I <= 1'b0;
        #1 chk(RD_DATA_O, want);
    endtask
    task automatic t_pc;
        chk(FETCH_ADDR_O, 24'h0);
        chk(IN_IVT_O, 1'b0);
        @(posedge CLOCK_I);
        PC_STEP_I <= 1'b1;
        repeat (3) @(posedge CLOCK_I);
        PC_DOWN_I <= 1'b1;
        @(posedge CLOCK_I);
        PC_STEP_I <= 1'b0;
        PC_DOWN_I <= 1'b0;
        PC_LOAD_I <= 1'b1;
        PC_LOAD_VAL_I <= 23'h105;
        #1 chk(FETCH_ADDR_O, 24'h4);
        chk(IN_IVT_O, 1'b1);
        @(posedge CLOCK_I);
        PC_LOAD_I <= 1'b0;
        #1 chk(FETCH_ADDR_O, 24'h104);
        chk(IN_ALT_IVT_O, 1'b1);
    endtask
    task automatic t_table;
        logic [23:0] adr [11] = '{24'h000100, 24'h004000, 24'h7FFE00, 24'hF80000, 24'hF80004,
            24'hF80006, 24'hF80008, 24'hF8000A, 24'hF8000C, 24'hF8000E, 24'hF80010};
        for (int i = 0; i < 11; i++)
        begin
            @(posedge CLOCK_I);
            TABLE_READ_OP_I <= 1'b1;
            TABLE_PAGE_REG_I <= adr[i][23:16];
            TABLE_OFFSET_I <= adr[i][15:0];
            #1 chk(TABLE_ADDR_O, adr[i]);
            chk(TABLE_REGION_O, (i < 3) ? 24'(i) : 24'h3);
            chk(CFG_WORD_O, (i < 3) ? 24'h0 : 24'(i - 2));
        end
        @(posedge CLOCK_I);
        TABLE_READ_OP_I <= 1'b0;
        TABLE_WRITE_OP_I <= 1'b1;
        TABLE_PAGE_REG_I <= 8'h7F;
        TABLE_OFFSET_I <= 16'hFE10;
        TABLE_WDATA_I <= 16'hA5C3;
        @(posedge CLOCK_I);
        TABLE_WRITE_OP_I <= 1'b0;
        TABLE_READ_OP_I <= 1'b1;
        @(posedge CLOCK_I);
        TABLE_OFFSET_I <= 16'hFE11;
        #1 chk(TABLE_RDATA_O, 16'hA5C3);
        @(posedge CLOCK_I);
        TABLE_READ_OP_I <= 1'b0;
        TABLE_PAGE_REG_I <= 8'hF8;
        #1 chk(TABLE_RDATA_O, 16'h0);
        chk(TABLE_DENIED_O, 1'b1);
        chk(TABLE_REGION_O, 24'h4);
    endtask
    task automatic t_data;
        wr(1'b0, 16'h0010, 16'h1234);
        rd(1'b0, 16'h0010, 16'h0, 16'h1234);
        wr(1'b1, 16'h0011, 16'h00AB);
        rd(1'b0, 16'h0010, 16'h0, 16'hAB34);
        rd(1'b1, 16'h0011, 16'h5500, 16'h55AB);
        @(posedge CLOCK_I);
        SIGN_EXTEND_OP_I <= 1'b1;
        rd(1'b1, 16'h0011, 16'h5500, 16'hFFAB);
        @(posedge CLOCK_I);
        SIGN_EXTEND_OP_I <= 1'b0;
        ZERO_EXTEND_OP_I <= 1'b1;
        rd(1'b1, 16'h0011, 16'h5500, 16'h00AB);
        @(posedge CLOCK_I);
        ZERO_EXTEND_OP_I <= 1'b0;
        rd(1'b0, 16'h0600, 16'h0, 16'h0);
        rd(1'b1, 16'h0601, 16'h7700, 16'h7700);
        rd(1'b0, 16'h8000, 16'h0, 16'h0);
    endtask
    task automatic t_agu;
        @(posedge CLOCK_I);
        WR_EN_I <= 1'b1;
        WR_BYTE_I <= 1'b0;
        WR_ADDR_I <= 16'h0020;
        WR_DATA_I <= 16'hC0DE;
        RD_EN_I <= 1'b1;
        RD_BYTE_I <= 1'b0;
        MEMORY_DIRECT_ADDRESSING_I <= 1'b0;
        DIRECT_NEAR_I <= 1'b1;
        NEAR_FIELD_I <= 13'h0010;
        @(posedge CLOCK_I);
        WR_EN_I <= 1'b0;
        RD_EN_I <= 1'b0;
        DIRECT_NEAR_I <= 1'b0;
        #1 chk(RD_DATA_O, 16'hAB34);
        rd(1'b0, 16'h0020, 16'h0, 16'hC0DE);
        @(posedge CLOCK_I);
        POST_INC_I <= 1'b1;
        SOURCE_POINTER_REG_I <= 16'h1FFE;
        RD_BYTE_I <= 1'b1;
        WR_BYTE_I <= 1'b1;
        #1 chk(POINTER_NEXT_O, 16'h1FFF);
        @(posedge CLOCK_I);
        RD_BYTE_I <= 1'b0;
        WR_BYTE_I <= 1'b0;
        #1 chk(POINTER_NEXT_O, 16'h2000);
        @(posedge CLOCK_I);
        POST_INC_I <= 1'b0;
        DIRECT_FIELD_I <= 16'h8000;
        PROGRAM_SPACE_WINDOW_I <= 1'b1;
        #1 chk(RD_WINDOW_O, 1'b1);
        @(posedge CLOCK_I);
        PROGRAM_SPACE_WINDOW_I <= 1'b0;
        #1 chk(RD_WINDOW_O, 1'b0);
    endtask
    task automatic t_trap;
        wr(1'b0, 16'h0012, 16'h5A5A);
        @(posedge CLOCK_I);
        WR_EN_I <= 1'b1;
        WR_ADDR_I <= 16'h0013;
        WR_DATA_I <= 16'hFFFF;
        #1 chk(ADDR_TRAP_O, 1'b1);
        @(posedge CLOCK_I);
        WR_EN_I <= 1'b0;
        #1 chk(ADDR_TRAP_O, 1'b1);
        // the core model takes the trap a few cycles later
        repeat (10)
        begin
            @(posedge CLOCK_I);
            #1;
            if (ADDR_TRAP_O === 1'b0)
                break;
        end
        chk(ADDR_TRAP_O, 1'b0);
        rd(1'b0, 16'h0012, 16'h0, 16'h5A5A);
        // misaligned read still completes with the aligned word and raises the trap
        rd(1'b0, 16'h0013, 16'h0, 16'h5A5A);
        chk(ADDR_TRAP_O, 1'b1);
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge CLOCK_I);
        SYS_RST_I <= 1'b0;
        @(posedge CLOCK_I);
        #1;
        t_pc;
        t_table;
        t_data;
        t_agu;
        t_trap;
        print_verdict;
    end
    initial
    begin
        #50000;
        n_errors++;
        print_verdict;
    end
endmodule
